// ---- logic/sysref_pulse_gen_phase_delay.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Clock phase delay per channel, 256 steps of one VCO period.
// - SYSREF coarse delay per output, 8 half-period steps.
// - SYSREF fine delay, 8 codes: 0,25,50,75,85,110,135,160 ps.
// - Global SYSREF delay, 256 steps, shifts all outputs together.
// - All delay settings are zero after reset.
// - Clock inverts when delay equals half its period.
// - Coincidence divider gates SYSREF start to common clock edges.
// - Event starts by software or external trigger; 1 to 255 pulses.
// - Counted mode stops after the count and powers output down.
// - Continuous mode runs free and ignores the pulse count.
// - Mode bit: 0 counted, 1 continuous; global to all outputs.
// - Pulse period from twelve selectable ratios, 64 to 5120.
// - Outputs power on at event start and off after it.
// - Idle-bias bit gives crosspoint rest, only with idle-level select 1.
// - Internal source: release enables outputs, loads count, starts aligned.
// - After the pulses, output rests low or at crosspoint bias.
// - External source: release arms, next trigger rising edge starts.
// - External mode uses mode bit and count as internal does.
// - Pulses align to coincident rising clock edges.
// - Delays do not depend on internal or external source.
// - Idle low with select 0, crosspoint with 1 and idle-bias bit set; toggles only in event.
module sysref_pulse_gen_phase_delay (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic external_trigger_input,
  input wire logic sysref_release_command,
  input wire logic sysref_source_select,
  input wire logic sysref_continuous_select,
  input wire logic [sysref_pkg::CNT_W-1:0] sysref_pulse_count,
  input wire logic [sysref_pkg::RATE_SEL_W-1:0] sysref_rate_divider,
  input wire logic [sysref_pkg::COIN_W-1:0] coincidence_div,
  input wire logic [sysref_pkg::NUM_CLK-1:0][sysref_pkg::DIV_W-1:0] channel_div,
  input wire logic [sysref_pkg::NUM_CLK-1:0][sysref_pkg::DLY_W-1:0] clk_phase_delay,
  input wire logic [sysref_pkg::NUM_REF-1:0][sysref_pkg::COARSE_W-1:0] ref_coarse_delay,
  input wire logic [sysref_pkg::NUM_REF-1:0][sysref_pkg::FINE_W-1:0] ref_fine_delay,
  input wire logic [sysref_pkg::DLY_W-1:0] global_delay,
  input wire logic [sysref_pkg::NUM_REF-1:0] idle_bias_enable,
  input wire logic idle_level_select,
  output logic [sysref_pkg::NUM_CLK-1:0] clock_output,
  output logic [sysref_pkg::NUM_REF-1:0] sysref_output,
  output logic [sysref_pkg::NUM_REF-1:0] sysref_power_on,
  output logic [sysref_pkg::NUM_REF-1:0] sysref_bias_mid,
  output logic [sysref_pkg::NUM_REF-1:0][sysref_pkg::FINE_PS_W-1:0] sysref_fine_ps,
  output logic sysref_busy
);
  import sysref_pkg::*;

  typedef struct packed {
    ev_state_t state;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic coin_started;
    logic [COIN_W-1:0] coin_cnt;
    logic cont;
    logic [CNT_W-1:0] left;
    logic [RATE_W-1:0] rate_cnt;
    logic [RATE_W-1:0] ratio;
    logic pulse;
    logic active;
    logic [NUM_CLK-1:0][DLY_W-1:0] clk_dly;
    logic [NUM_REF-1:0][COARSE_W-1:0] coarse;
    logic [NUM_REF-1:0][FINE_W-1:0] fine;
    logic [DLY_W-1:0] global_dly;
    logic [NUM_REF-1:0] bias;
    logic [NUM_REF-1:0][FINE_PS_W-1:0] fine_out;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;
  logic trig_rise;
  logic coin_point;
  logic period_end;
  logic [1:0] global_out;
  logic [NUM_REF-1:0][1:0] ref_out;

  assign trig_rise = st_reg.trig_s2 && !st_reg.trig_s3;
  assign coin_point = st_reg.coin_started && (st_reg.coin_cnt == COIN_RESET);
  assign period_end = (st_reg.rate_cnt >= st_reg.ratio - RATE_W'(1));

  // Event sequencing, coincidence counter and setting capture
  always_comb begin
    st_next = st_reg;
    st_next.trig_s1 = external_trigger_input;
    st_next.trig_s2 = st_reg.trig_s1;
    st_next.trig_s3 = st_reg.trig_s2;
    st_next.clk_dly = clk_phase_delay;
    st_next.coarse = ref_coarse_delay;
    st_next.fine = ref_fine_delay;
    st_next.global_dly = global_delay;
    st_next.coin_started = 1'b1;
    if (st_reg.coin_started) begin
      if (st_reg.coin_cnt >= coincidence_div - COIN_W'(1)) begin
        st_next.coin_cnt = COIN_RESET;
      end else begin
        st_next.coin_cnt = st_reg.coin_cnt + COIN_W'(1);
      end
    end
    unique case (st_reg.state)
      ST_IDLE: begin
        st_next.active = 1'b0;
        st_next.pulse = 1'b0;
        // start request, count 1 to 255
        if (sysref_release_command
            && (sysref_continuous_select || sysref_pulse_count != CNT_RESET)) begin
          st_next.cont = sysref_continuous_select;
          st_next.left = sysref_pulse_count;
          st_next.ratio = rate_ratio(sysref_rate_divider);
          st_next.state = sysref_source_select ? ST_ARMED : ST_ALIGN;
        end
      end
      ST_ARMED: begin
        // mode and count kept from release
        if (trig_rise) begin
          st_next.state = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        if (coin_point) begin
          st_next.state = ST_RUN;
          st_next.active = 1'b1;
          st_next.pulse = 1'b1;
          st_next.rate_cnt = RATE_RESET;
        end
      end
      ST_RUN: begin
        if (period_end) begin
          st_next.rate_cnt = RATE_RESET;
          st_next.pulse = 1'b1;
          if (st_reg.cont) begin
            if (!sysref_continuous_select) begin
              st_next.state = ST_IDLE;
              st_next.active = 1'b0;
              st_next.pulse = 1'b0;
            end
          end else if (st_reg.left <= CNT_W'(1)) begin
            st_next.state = ST_IDLE;
            st_next.active = 1'b0;
            st_next.pulse = 1'b0;
            st_next.left = CNT_RESET;
          end else begin
            st_next.left = st_reg.left - CNT_W'(1);
          end
        end else begin
          st_next.rate_cnt = st_reg.rate_cnt + RATE_W'(1);
          st_next.pulse = (st_reg.rate_cnt + RATE_W'(1)) < (st_reg.ratio >> 1);
        end
      end
    endcase
    st_next.bias = idle_level_select ? idle_bias_enable : '0;
    for (int q = 0; q < NUM_REF; q++) begin
      st_next.fine_out[q] = fine_ps(st_reg.fine[q]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  genvar c;
  generate
    for (c = 0; c < NUM_CLK; c++) begin : g_clk
      clk_channel_div u_ch (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .div_ratio(channel_div[c]),
        .phase_delay(st_reg.clk_dly[c]),
        .clock_output(clock_output[c])
      );
    end
  endgenerate

  // one delay path for both sources
  sysref_delay_line #(
    .DEPTH(GLOBAL_DEPTH),
    .SEL_W(DLY_W)
  ) u_global (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .delay(st_reg.global_dly),
    .data_in({st_reg.active, st_reg.pulse}),
    .data_out(global_out)
  );

  genvar r;
  generate
    for (r = 0; r < NUM_REF; r++) begin : g_ref
      sysref_delay_line #(
        .DEPTH(COARSE_DEPTH),
        .SEL_W(COARSE_W)
      ) u_coarse (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .delay(st_reg.coarse[r]),
        .data_in(global_out),
        .data_out(ref_out[r])
      );
      assign sysref_power_on[r] = ref_out[r][1];
      assign sysref_output[r] = ref_out[r][1] & ref_out[r][0];
      assign sysref_bias_mid[r] = !ref_out[r][1] & st_reg.bias[r];
    end
  endgenerate

  assign sysref_fine_ps = st_reg.fine_out;
  assign sysref_busy = (st_reg.state != ST_IDLE);

  // Checks on the event sequence
  a_reset_zero: assert property (@(posedge core_clk)
    $past(rst) && !rst |-> st_reg.global_dly == DLY_RESET && st_reg.coarse == '0
      && st_reg.clk_dly == '0 && st_reg.fine == '0)
    else $error("delay settings not zero after reset");

  a_start_coin: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_ALIGN && !coin_point |=> st_reg.state == ST_ALIGN)
    else $error("event left alignment off a coincidence point");

  a_ext_arm: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_ARMED && !trig_rise |=> st_reg.state == ST_ARMED)
    else $error("armed event started without trigger edge");

  a_int_release: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_IDLE && sysref_release_command && !sysref_source_select
      && sysref_pulse_count != CNT_RESET
    |=> st_reg.state == ST_ALIGN && st_reg.left == $past(sysref_pulse_count))
    else $error("internal release did not load count");

  a_count_end: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_RUN && !st_reg.cont && period_end
      && st_reg.left == CNT_W'(1) |=> st_reg.state == ST_IDLE && !st_reg.active)
    else $error("counted event did not end on last pulse");

  a_count_dec: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_RUN && !st_reg.cont && period_end
      && st_reg.left > CNT_W'(1) |=> st_reg.left == $past(st_reg.left) - CNT_W'(1))
    else $error("pulse counter did not step down");

  a_cont_hold: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_RUN && st_reg.cont && sysref_continuous_select
    |=> st_reg.state == ST_RUN && st_reg.left == $past(st_reg.left))
    else $error("continuous mode stopped or counted");

  a_busy_ignore: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_RUN && !period_end |=> st_reg.state == ST_RUN)
    else $error("event disturbed while running");

  a_bias_rest: assert property (@(posedge core_clk) disable iff (rst)
    $past(clk_en) && sysref_bias_mid != '0 |-> $past(idle_level_select)
      && (sysref_bias_mid & ~$past(idle_bias_enable)) == '0)
    else $error("crosspoint bias without idle-level select");

  a_idle_quiet: assert property (@(posedge core_clk) disable iff (rst)
    st_reg.state == ST_IDLE |-> !st_reg.active && !st_reg.pulse
      && (sysref_output & ~sysref_power_on) == '0)
    else $error("output toggled while powered down");

  // Checks on mode, count, alignment and power

  a_mode_latch: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_IDLE && sysref_release_command && sysref_continuous_select
    |=> st_reg.cont && st_reg.state != ST_IDLE)
    else $error("continuous mode bit not latched at release");

  a_zero_refused: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_IDLE && !sysref_continuous_select
      && sysref_pulse_count == CNT_RESET |=> st_reg.state == ST_IDLE)
    else $error("release with zero pulse count was taken");

  a_arm_entry: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_IDLE && sysref_release_command && sysref_source_select
      && sysref_pulse_count != CNT_RESET |=> st_reg.state == ST_ARMED)
    else $error("external release did not arm");

  a_ext_same: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_ARMED && trig_rise |=> st_reg.state == ST_ALIGN
      && st_reg.left == $past(st_reg.left) && st_reg.cont == $past(st_reg.cont))
    else $error("trigger changed the latched mode or count");

  a_run_on_coin: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_ALIGN && coin_point
    |=> st_reg.state == ST_RUN && st_reg.active && st_reg.pulse
      && st_reg.rate_cnt == RATE_RESET)
    else $error("event did not start on a coincidence point");

  a_period_wrap: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_RUN && period_end
      && (st_reg.cont ? sysref_continuous_select : st_reg.left > CNT_W'(1))
    |=> st_reg.state == ST_RUN && st_reg.rate_cnt == RATE_RESET && st_reg.pulse)
    else $error("pulse period did not restart");

  a_hold_settings: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && (st_reg.state == ST_ARMED || st_reg.state == ST_ALIGN)
    |=> st_reg.left == $past(st_reg.left) && st_reg.ratio == $past(st_reg.ratio))
    else $error("pending event took a new release");

  a_power_run: assert property (@(posedge core_clk) disable iff (rst)
    st_reg.state == ST_RUN |-> st_reg.active)
    else $error("event running with outputs powered down");

  a_cont_ends: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == ST_RUN && st_reg.cont && period_end && !sysref_continuous_select
    |=> st_reg.state == ST_IDLE && !st_reg.active)
    else $error("continuous event did not stop at period end");

  // Coverage of the main scenarios
  c_counted: cover property (@(posedge core_clk) disable iff (rst)
    st_reg.state == ST_RUN && !st_reg.cont ##1 st_reg.state == ST_IDLE);
  c_external: cover property (@(posedge core_clk) disable iff (rst)
    st_reg.state == ST_ARMED ##1 st_reg.state == ST_ALIGN);
  c_continuous: cover property (@(posedge core_clk) disable iff (rst)
    st_reg.state == ST_RUN && st_reg.cont && period_end);
  c_bias: cover property (@(posedge core_clk) disable iff (rst)
    sysref_bias_mid[0] && !sysref_power_on[0]);
endmodule

// ---- logic/sysref_pkg.sv ----
package sysref_pkg;

  // Channel counts and field widths
  localparam int NUM_CLK = 5;
  localparam int NUM_REF = 4;
  localparam int DLY_W = 8;
  localparam int COARSE_W = 3;
  localparam int FINE_W = 3;
  localparam int CNT_W = 8;
  localparam int RATE_W = 13;
  localparam int RATE_SEL_W = 4;
  localparam int COIN_W = 7;
  localparam int DIV_W = 8;
  localparam int FINE_PS_W = 8;

  // Delay line depths, in steps
  localparam int GLOBAL_DEPTH = 256;
  localparam int COARSE_DEPTH = 8;

  // Step sizes in picoseconds; one core cycle models one step
  localparam int VCO_PERIOD_PS = 339;
  localparam int COARSE_STEP_PS = 169;

  // Values after reset
  localparam logic [DLY_W-1:0] DLY_RESET = 8'h00;
  localparam logic [COARSE_W-1:0] COARSE_RESET = 3'h0;
  localparam logic [FINE_W-1:0] FINE_RESET = 3'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [RATE_W-1:0] RATE_RESET = 13'h0000;
  localparam logic [COIN_W-1:0] COIN_RESET = 7'h00;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_ALIGN = 2'b10,
    ST_RUN   = 2'b11
  } ev_state_t;

  // Nominal fine delay of each code, picoseconds
  function automatic logic [FINE_PS_W-1:0] fine_ps(input logic [FINE_W-1:0] code);
    unique case (code)
      3'h0: fine_ps = 8'h00;
      3'h1: fine_ps = 8'h19;
      3'h2: fine_ps = 8'h32;
      3'h3: fine_ps = 8'h4B;
      3'h4: fine_ps = 8'h55;
      3'h5: fine_ps = 8'h6E;
      3'h6: fine_ps = 8'h87;
      3'h7: fine_ps = 8'hA0;
    endcase
  endfunction

  // Pulse period in steps for each rate select code
  function automatic logic [RATE_W-1:0] rate_ratio(input logic [RATE_SEL_W-1:0] sel);
    case (sel)
      4'h0: rate_ratio = 13'h0040;
      4'h1: rate_ratio = 13'h0060;
      4'h2: rate_ratio = 13'h0080;
      4'h3: rate_ratio = 13'h00C0;
      4'h4: rate_ratio = 13'h0100;
      4'h5: rate_ratio = 13'h0180;
      4'h6: rate_ratio = 13'h0200;
      4'h7: rate_ratio = 13'h0300;
      4'h8: rate_ratio = 13'h0400;
      4'h9: rate_ratio = 13'h0800;
      4'hA: rate_ratio = 13'h1000;
      4'hB: rate_ratio = 13'h1400;
      default: rate_ratio = 13'h0040;
    endcase
  endfunction

endpackage

// ---- logic/sysref_delay_line.sv ----
`timescale 1ns/1ps
// Variable tap delay of a two-bit word {active, pulse}, one step per cycle
module sysref_delay_line #(
  parameter int DEPTH = 8,
  parameter int SEL_W = 3
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [SEL_W-1:0] delay,
  input wire logic [1:0] data_in,
  output logic [1:0] data_out
);
  import sysref_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][1:0] line;
    logic [1:0] out;
  } dl_state_t;

  dl_state_t st_reg;
  dl_state_t st_next;

  // Shift and tap select
  always_comb begin
    st_next = st_reg;
    st_next.line = {st_reg.line[DEPTH-2:0], data_in};
    if (delay == '0) begin
      st_next.out = data_in;
    end else begin
      st_next.out = st_reg.line[delay - SEL_W'(1)];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign data_out = st_reg.out;
endmodule

// ---- logic/clk_channel_div.sv ----
`timescale 1ns/1ps
// One clock channel: divider started after a programmable hold
module clk_channel_div (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [sysref_pkg::DIV_W-1:0] div_ratio,
  input wire logic [sysref_pkg::DLY_W-1:0] phase_delay,
  output logic clock_output
);
  import sysref_pkg::*;

  typedef struct packed {
    logic started;
    logic done;
    logic [DLY_W-1:0] hold;
    logic [DIV_W-1:0] cnt;
    logic out;
  } ch_state_t;

  ch_state_t st_reg;
  ch_state_t st_next;
  logic [DIV_W-1:0] last;

  // Hold for the delay, then count the divider and shape the clock
  always_comb begin
    st_next = st_reg;
    last = (div_ratio == '0) ? '0 : div_ratio - DIV_W'(1);
    // First cycle after reset waits for the registered delay setting
    st_next.started = 1'b1;
    if (!st_reg.started) begin
      st_next.done = 1'b0;
    end else if (!st_reg.done) begin
      if (st_reg.hold == phase_delay) begin
        st_next.done = 1'b1;
      end else begin
        st_next.hold = st_reg.hold + DLY_W'(1);
      end
    end else if (st_reg.cnt >= last) begin
      st_next.cnt = '0;
    end else begin
      st_next.cnt = st_reg.cnt + DIV_W'(1);
    end
    // half-period hold gives the inverted clock
    st_next.out = st_next.done && (st_next.cnt < (div_ratio >> 1));
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign clock_output = st_reg.out;
endmodule

// ---- tb/converter_model.sv ----
`timescale 1ns/1ps
// Receiving converter: counts SYSREF pulses and checks idle quiet
module converter_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic [3:0] sysref_output,
  input wire logic [3:0] sysref_power_on,
  output logic [15:0] seen_count,
  output logic [15:0] high_width,
  output logic [7:0] fault_count
);
  logic [15:0] run_len;
  logic last_ref;
  // Pulse count and high width of channel 0
  // toggling only while powered
  always_ff @(posedge core_clk) begin
    if (rst || clear) begin
      seen_count <= 16'h0000;
      high_width <= 16'h0000;
      run_len <= 16'h0000;
      last_ref <= 1'b0;
      fault_count <= 8'h00;
    end else begin
      last_ref <= sysref_output[0];
      if (sysref_output[0] && !last_ref) seen_count <= seen_count + 16'h0001;
      if (sysref_output[0]) run_len <= run_len + 16'h0001;
      else run_len <= 16'h0000;
      if (!sysref_output[0] && last_ref) high_width <= run_len;
      if ((sysref_output & ~sysref_power_on) != 4'h0) fault_count <= fault_count + 8'h01;
    end
  end
endmodule

// ---- tb/sysref_pulse_gen_phase_delay_bench.sv ----
`timescale 1ns/1ps
module sysref_pulse_gen_phase_delay_bench;
  import sysref_pkg::*;
  typedef struct {int cnt; int width;} note_t;
  logic core_clk, rst, clk_en, trig, rel, src, cont, idle_sel, clear;
  logic [CNT_W-1:0] pcount;
  logic [RATE_SEL_W-1:0] rate;
  logic [COIN_W-1:0] coin;
  logic [NUM_CLK-1:0][DIV_W-1:0] ch_div;
  logic [NUM_CLK-1:0][DLY_W-1:0] ph_dly;
  logic [NUM_REF-1:0][COARSE_W-1:0] coarse;
  logic [NUM_REF-1:0][FINE_W-1:0] fine;
  logic [DLY_W-1:0] gdly;
  logic [NUM_REF-1:0] bias_en, ref_out, pwr, mid;
  logic [NUM_CLK-1:0] clk_out;
  logic [NUM_REF-1:0][FINE_PS_W-1:0] fine_ps_out;
  logic busy;
  logic [15:0] seen_count, high_width;
  logic [7:0] fault_count;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'h7ed3;
  int ratio[12] = '{64, 96, 128, 192, 256, 384, 512, 768, 1024, 2048, 4096, 5120};
  int ps_tab[8] = '{0, 25, 50, 75, 85, 110, 135, 160};
  note_t notes[$];

  sysref_pulse_gen_phase_delay dut_u (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .external_trigger_input(trig), .sysref_release_command(rel), .sysref_source_select(src),
    .sysref_continuous_select(cont), .sysref_pulse_count(pcount), .sysref_rate_divider(rate),
    .coincidence_div(coin), .channel_div(ch_div), .clk_phase_delay(ph_dly),
    .ref_coarse_delay(coarse), .ref_fine_delay(fine), .global_delay(gdly),
    .idle_bias_enable(bias_en), .idle_level_select(idle_sel), .clock_output(clk_out),
    .sysref_output(ref_out), .sysref_power_on(pwr), .sysref_bias_mid(mid),
    .sysref_fine_ps(fine_ps_out), .sysref_busy(busy));
  converter_model conv_u (.core_clk(core_clk), .rst(rst), .clear(clear),
    .sysref_output(ref_out), .sysref_power_on(pwr), .seen_count(seen_count),
    .high_width(high_width), .fault_count(fault_count));

  // Clock source
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Bounded wait for busy to reach a level
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 40000 && busy !== lvl; i++) @(posedge core_clk);
    if (busy !== lvl) check_val(16'h0000, 16'h0001, "busy wait");
  endtask

  // One event; optional second release and trigger while running
  task automatic run_event(input logic s, input logic c, input int n, input int k,
                           input logic again);
    note_t nt;
    @(posedge core_clk);
    src <= s;
    cont <= c;
    pcount <= n[7:0];
    rate <= k[3:0];
    clear <= 1'b1;
    @(posedge core_clk);
    clear <= 1'b0;
    rel <= 1'b1;
    nt.cnt = c ? 0 : n;
    nt.width = ratio[k] / 2;
    notes.push_back(nt);
    @(posedge core_clk);
    rel <= 1'b0;
    if (s) begin
      repeat (4) @(posedge core_clk);
      trig <= 1'b1;
      repeat (6) @(posedge core_clk);
      trig <= 1'b0;
    end
    wait_busy(1'b1);
    if (again) begin
      repeat (20) @(posedge core_clk);
      rel <= 1'b1;
      trig <= 1'b1;
      @(posedge core_clk);
      rel <= 1'b0;
      repeat (5) @(posedge core_clk);
      trig <= 1'b0;
    end
    if (c) begin
      repeat (4 * ratio[k]) @(posedge core_clk);
      cont <= 1'b0;
    end
    wait_busy(1'b0);
    repeat (90) @(posedge core_clk);
  endtask

  // Watcher: compares each finished event with the oldest note
  initial begin
    note_t nt;
    forever begin
      @(negedge busy);
      if (notes.size() > 0) begin
        repeat (80) @(posedge core_clk);
        #1;
        nt = notes.pop_front();
        if (nt.cnt == 0) check_val({15'h0000, seen_count > 16'h0002}, 16'h0001, "run");
        else check_val(seen_count, nt.cnt[15:0], "pulse count");
        check_val(high_width, nt.width[15:0], "pulse width");
        check_val({8'h00, fault_count}, 16'h0000, "idle toggle");
        check_val({12'h000, pwr}, 16'h0000, "power down");
        check_val({12'h000, mid}, {12'h000, idle_sel ? bias_en : 4'h0}, "rest level");
      end
    end
  end

  // Watchdog
  initial begin
    repeat (90000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    int i, k;
    rst = 1'b1; clk_en = 1'b1; trig = 1'b0; rel = 1'b0; src = 1'b0; cont = 1'b0;
    idle_sel = 1'b0; clear = 1'b0; pcount = 8'h01; rate = 4'h0; gdly = 8'h00;
    // coincidence set to common multiple of channel dividers
    coin = 7'h04;
    ch_div = {NUM_CLK{8'h04}};
    ph_dly = '0;
    ph_dly[1] = 8'h02;
    coarse = '0; fine = '0; bias_en = 4'h0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    check_val({pwr, mid, ref_out, 4'h0}, 16'h0000, "reset outputs");
    check_val({8'h00, fine_ps_out[0]}, 16'h0000, "reset fine");
    repeat (30) @(posedge core_clk);
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk);
      #1;
      check_val({15'h0000, clk_out[1]}, {15'h0000, ~clk_out[0]}, "half period");
      check_val({13'h0000, clk_out[4:2]}, {13'h0000, {3{clk_out[0]}}}, "aligned");
    end
    for (k = 0; k < 8; k++) begin
      @(posedge core_clk);
      for (i = 0; i < NUM_REF; i++) fine[i] <= 3'((k + i) % 8);
      repeat (3) @(posedge core_clk);
      #1;
      for (i = 0; i < NUM_REF; i++) begin
        check_val({8'h00, fine_ps_out[i]}, 16'(ps_tab[(k + i) % 8]), "fine");
      end
    end
    @(posedge core_clk);
    idle_sel <= 1'b1;
    bias_en <= 4'h5;
    repeat (3) @(posedge core_clk);
    #1;
    check_val({12'h000, mid}, 16'h0005, "bias rest");
    @(posedge core_clk);
    idle_sel <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    check_val({12'h000, mid}, 16'h0000, "bias off");
    @(posedge core_clk);
    pcount <= 8'h00;
    rel <= 1'b1;
    @(posedge core_clk);
    rel <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check_val({15'h0000, busy}, 16'h0000, "zero count");
    for (k = 0; k < 12; k++) begin
      @(posedge core_clk);
      gdly <= 8'($unsigned($random(seed)) % 32);
      for (i = 0; i < NUM_REF; i++) coarse[i] <= 3'($random(seed));
      run_event(1'b0, 1'b0, 1 + (k % 3), k, 1'b0);
    end
    run_event(1'b0, 1'b0, 255, 0, 1'b0);
    run_event(1'b1, 1'b0, 1 + ($unsigned($random(seed)) % 6), 1, 1'b1);
    run_event(1'b0, 1'b1, 1, 0, 1'b0);
    @(posedge core_clk);
    gdly <= 8'h29;
    coarse <= {NUM_REF{3'h1}};
    fine <= {NUM_REF{3'h1}};
    run_event(1'b1, 1'b0, 2, 5, 1'b0);
    run_event(1'b1, 1'b1, 1, 2, 1'b1);
    give_verdict();
  end
endmodule
